// >>> atdc_chk.sv
`default_nettype none
module atdc_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic cmd_valid,
  input wire logic permit,
  input wire logic ib_advance,
  input wire logic done,
  input wire logic prefetch_ok,
  input wire logic [29:0] instruction_physical_address,
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic mem_quad,
  input wire logic [29:0] mem_addr,
  input wire logic mem_ack
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  property p_done_pulse;
    done |=> !done;
  endproperty
  a_done_pulse: assert property (p_done_pulse)
    else $error("done held over one cycle");
  property p_done_valid;
    done |-> cmd_valid;
  endproperty
  a_done_valid: assert property (p_done_valid)
    else $error("done without a pending command");
  property p_mem_hold;
    mem_req && !mem_ack |=> mem_req && $stable(mem_addr) && $stable(mem_we);
  endproperty
  a_mem_hold: assert property (p_mem_hold)
    else $error("memory request changed before ack");
  property p_io_long;
    mem_req && mem_addr[29] |-> !mem_quad;
  endproperty
  a_io_long: assert property (p_io_long)
    else $error("io access asked for a quadword");
  property p_quad_align;
    mem_req && mem_quad |-> mem_addr[2:0] == 3'h0 && !mem_we;
  endproperty
  a_quad_align: assert property (p_quad_align)
    else $error("quadword fill misaligned");
  property p_wr_long;
    mem_req && mem_we |-> !mem_quad;
  endproperty
  a_wr_long: assert property (p_wr_long)
    else $error("write sent as quadword");
  property p_ipa_step;
    ib_advance && prefetch_ok |=> instruction_physical_address == $past(instruction_physical_address) + 30'h4;
  endproperty
  a_ipa_step: assert property (p_ipa_step)
    else $error("ipa did not step with lookahead");
  property p_cross;
    ib_advance && prefetch_ok && instruction_physical_address[8:0] == 9'h1FC |=> !prefetch_ok;
  endproperty
  a_cross: assert property (p_cross)
    else $error("prefetch kept after page cross");
  property p_no_reload;
    (!prefetch_ok && !cmd_valid && !permit) [*3] |=> !prefetch_ok;
  endproperty
  a_no_reload: assert property (p_no_reload)
    else $error("prefetch resumed without permit");
endmodule
`default_nettype wire

// >>> atdc_defines.svh
`ifndef ATDC_DEFINES_SVH
`define ATDC_DEFINES_SVH
`define ATDC_PCLK_MHZ 100
`define ATDC_STALL_NS 200
`define ATDC_STALL_CYC ((`ATDC_STALL_NS*`ATDC_PCLK_MHZ+999)/1000)
`define ATDC_TB_SETS 64
`define ATDC_DC_SETS 512
`define ATDC_DC_CLR_CNT 1024
`define ATDC_TB_CLR_CNT 64
`define ATDC_IO_BIT 29
`define ATDC_TBE_VALID 31
`define ATDC_TBE_MASK 32'h801F_FFFF
`define ATDC_LFSR_SEED 16'hACE1
`define ATDC_LFSR_TAPS 16'hB400
`define ATDC_R_CTRL 8'h00
`define ATDC_R_VA 8'h04
`define ATDC_R_WDATA 8'h08
`define ATDC_R_CMD 8'h0C
`define ATDC_R_STAT 8'h10
`define ATDC_R_RDATA 8'h14
`define ATDC_R_IPA 8'h18
`define ATDC_R_LA 8'h1C
`define ATDC_CTRL_RST 8'h00
`define ATDC_C_MME 0
`define ATDC_C_PHYS 1
`define ATDC_C_RB 2
`define ATDC_C_TBFM 4
`define ATDC_C_DCFM 6
`define ATDC_K_GO 3
`define ATDC_K_PERMIT 4
`define ATDC_K_ADV 5
`define ATDC_K_SWEEP 6
`define ATDC_S_BUSY 0
`define ATDC_S_ERR 1
`define ATDC_S_POK 2
`define ATDC_S_REF 3
`define ATDC_S_WCHK 4
`endif

// >>> atdc_dev.sv
// What this block does
// [RULE1] 64-set two-way lookaside, index bits 14:9
// [RULE2] translate va or lookahead; bypass physical/unmapped
// [RULE3] ipa steps with lookahead; page cross stops
// [RULE4] reload starts on permit; stalls next request
// [RULE5] resume after reload; error keeps prefetch stopped
// [RULE6] reload runs even with mapping disabled
// [RULE7] new pc read loads ipa from va
// [RULE8] select va, ipa or translation as address
// [RULE9] two cache groups, tag per quadword
// [RULE10] hit returns longword; miss fills quadword
// [RULE11] io reads fetch longword, never allocate
// [RULE12] fill group chosen randomly
// [RULE13] writes go through; miss allocates nothing
// [RULE14] reload only on permit; flush aborts it
// [RULE15] cache clear hits both groups at once
// [RULE16] zero word with replace-both clears entry
// [RULE17] requester keeps reserved entry bits zero
// [RULE18] forced cache misses still work correctly
// [RULE19] flush clears prefetch error state
// [RULE20] requester holds va and data during op
// [RULE21] new pc only while prefetch stopped
// [RULE22] write after write-check read matches it
// [RULE23] group pick from free-running random source
//
// The implementer's own choices: the register offsets and the APB slave port.
`default_nettype none
`include "atdc_defines.svh"
module atdc_dev (
  input wire logic pclk,
  input wire logic presetn,
  atdc_if.dev m,
  output logic mem_req,
  output logic mem_we,
  output logic mem_quad,
  output logic [29:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [63:0] mem_rdata
);
  atdc_pkg::atdc_dev_s s_ff, nxt_s;
  atdc_pkg::atdc_pasel_e pa_sel;
  logic [16:0] tb_tag_ff [2][`ATDC_TB_SETS];
  logic [20:0] tb_pfn_ff [2][`ATDC_TB_SETS];
  logic [17:0] dc_tag_ff [2][`ATDC_DC_SETS];
  logic [31:0] dc_data_ff [2][2*`ATDC_DC_SETS];
  logic rnd;
  logic [1:0] tb_we;
  logic [1:0] dcw_we;
  logic [1:0] hitv;
  logic dcf_we;
  logic [30:0] xv;
  logic [30:0] xl;
  logic [29:0] pa;
  logic hw, io, byp, mop, flush, xmiss;

  atdc_lfsr u_rnd (
    .pclk(pclk),
    .presetn(presetn),
    .bit_o(rnd)
  );

  // returns {hit, physical address}
  function automatic logic [30:0] xlate(input logic [31:0] a,
                                        input logic bypass);
    logic [5:0] i;
    logic [30:0] r;
    i = a[14:9]; // [RULE1]
    r = {1'b0, a[29:0]};
    if (bypass) begin
      r = {1'b1, a[29:0]};
    end else begin
      for (int w = 0; w < 2; w++) begin
        if (s_ff.tbv[w][i] && !m.tb_force_miss[w] &&
            tb_tag_ff[w][i] == a[31:15]) begin
          r = {1'b1, tb_pfn_ff[w][i], a[8:0]};
        end
      end
    end
    return r;
  endfunction

  always_comb begin
    nxt_s = s_ff;
    nxt_s.done = 1'b0;
    nxt_s.err = 1'b0;
    tb_we = 2'b00;
    dcw_we = 2'b00;
    dcf_we = 1'b0;
    byp = m.phys || !m.memory_mapping_enable; // [RULE2]
    xv = xlate(m.va, byp); // [RULE2]
    xl = xlate(m.lookahead, !m.memory_mapping_enable); // [RULE2] [RULE6]
    if (m.cmd == atdc_pkg::CMD_IFETCH) begin
      pa_sel = atdc_pkg::PS_IPA;
    end else if (byp) begin
      pa_sel = atdc_pkg::PS_VA;
    end else begin
      pa_sel = atdc_pkg::PS_XLT;
    end
    case (pa_sel) // [RULE8]
      atdc_pkg::PS_VA: pa = m.va[29:0];
      atdc_pkg::PS_IPA: pa = s_ff.instruction_physical_address;
      default: pa = xv[29:0];
    endcase
    xmiss = pa_sel == atdc_pkg::PS_XLT && !xv[30];
    io = pa[`ATDC_IO_BIT];
    for (int w = 0; w < 2; w++) begin
      hitv[w] = s_ff.dcv[w][pa[11:3]] && !m.dc_force_miss[w] &&
                dc_tag_ff[w][pa[11:3]] == pa[29:12]; // [RULE9] [RULE18]
    end
    hw = hitv[1];
    mop = m.cmd_valid && !s_ff.done && s_ff.st == atdc_pkg::D_IDLE;
    flush = mop && m.cmd == atdc_pkg::CMD_FLUSH;
    if (m.ib_advance && s_ff.ipa_ok) begin
      nxt_s.instruction_physical_address = s_ff.instruction_physical_address + 30'h4; // [RULE3]
      if (nxt_s.instruction_physical_address[8:0] == 9'h0) begin
        nxt_s.pcross = 1'b1; // [RULE3]
      end
    end
    if (m.permit && s_ff.pcross && !s_ff.rl_go && !s_ff.rl_err &&
        !flush) begin
      nxt_s.rl_go = 1'b1; // [RULE4] [RULE14]
    end
    if (flush) begin
      nxt_s.rl_go = 1'b0; // [RULE14]
      nxt_s.rl_err = 1'b0; // [RULE19]
      nxt_s.done = 1'b1;
    end else if (s_ff.rl_go) begin
      nxt_s.rl_go = 1'b0;
      if (xl[30]) begin
        nxt_s.instruction_physical_address = xl[29:0]; // [RULE5]
        nxt_s.pcross = 1'b0;
      end else begin
        nxt_s.rl_err = 1'b1; // [RULE5]
      end
      if (mop) begin
        nxt_s.st = atdc_pkg::D_STALL; // [RULE4]
        nxt_s.cnt = 5'(`ATDC_STALL_CYC - 1);
      end
    end else if (mop) begin
      case (m.cmd)
        atdc_pkg::CMD_READ, atdc_pkg::CMD_RDWCHK,
        atdc_pkg::CMD_IFETCH: begin
          if ((m.cmd == atdc_pkg::CMD_IFETCH && !s_ff.pok) || xmiss) begin
            nxt_s.done = 1'b1; // [RULE3]
            nxt_s.err = 1'b1;
          end else if (!io && |hitv) begin
            nxt_s.rdata = dc_data_ff[hw][pa[11:2]]; // [RULE10]
            nxt_s.done = 1'b1;
          end else begin
            nxt_s.mem_req = 1'b1;
            nxt_s.mem_we = 1'b0;
            nxt_s.mem_quad = !io; // [RULE10] [RULE11]
            nxt_s.mem_addr = io ? pa : {pa[29:3], 3'h0};
            nxt_s.fill = !io; // [RULE11]
            nxt_s.way = rnd; // [RULE12] [RULE23]
            nxt_s.pa = pa;
            nxt_s.st = atdc_pkg::D_MEM;
          end
        end
        atdc_pkg::CMD_WRITE: begin
          if (xmiss) begin
            nxt_s.done = 1'b1;
            nxt_s.err = 1'b1;
          end else begin
            nxt_s.mem_req = 1'b1; // [RULE13]
            nxt_s.mem_we = 1'b1;
            nxt_s.mem_quad = 1'b0;
            nxt_s.mem_addr = pa;
            nxt_s.mem_wdata = m.wdata;
            nxt_s.fill = 1'b0; // [RULE13]
            nxt_s.pa = pa;
            nxt_s.st = atdc_pkg::D_MEM;
            if (!io && |hitv) begin
              dcw_we[hw] = 1'b1; // [RULE13]
            end
          end
        end
        atdc_pkg::CMD_NEWPC: begin
          nxt_s.done = 1'b1;
          if (xmiss) begin
            nxt_s.err = 1'b1;
          end else begin
            nxt_s.instruction_physical_address = pa; // [RULE7]
            nxt_s.ipa_ok = 1'b1;
            nxt_s.pcross = 1'b0;
            nxt_s.rl_err = 1'b0;
          end
        end
        atdc_pkg::CMD_TBWR: begin
          tb_we = m.replace_both ? 2'b11 : (rnd ? 2'b10 : 2'b01);
          for (int w = 0; w < 2; w++) begin
            if (tb_we[w]) begin
              nxt_s.tbv[w][m.va[14:9]] = m.wdata[`ATDC_TBE_VALID]; // [RULE16]
            end
          end
          nxt_s.done = 1'b1;
        end
        atdc_pkg::CMD_CCLR: begin
          nxt_s.dcv[0][m.va[11:3]] = 1'b0; // [RULE15]
          nxt_s.dcv[1][m.va[11:3]] = 1'b0; // [RULE15]
          nxt_s.done = 1'b1;
        end
        default: nxt_s.done = 1'b1;
      endcase
    end
    case (s_ff.st)
      atdc_pkg::D_MEM: begin
        if (mem_ack) begin
          nxt_s.mem_req = 1'b0;
          if (!s_ff.mem_we) begin
            nxt_s.rdata = (s_ff.mem_quad && s_ff.pa[2]) ?
                          mem_rdata[63:32] : mem_rdata[31:0]; // [RULE10]
          end
          if (s_ff.fill) begin
            dcf_we = 1'b1; // [RULE10]
            nxt_s.dcv[s_ff.way][s_ff.pa[11:3]] = 1'b1;
          end
          nxt_s.done = 1'b1;
          nxt_s.st = atdc_pkg::D_IDLE;
        end
      end
      atdc_pkg::D_STALL: begin
        nxt_s.cnt = s_ff.cnt - 5'h1; // [RULE4]
        if (s_ff.cnt == 5'h0) begin
          nxt_s.st = atdc_pkg::D_IDLE;
        end
      end
      default: ;
    endcase
    nxt_s.pok = nxt_s.ipa_ok && !nxt_s.pcross && !nxt_s.rl_err; // [RULE5]
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  // lookaside and cache storage, valid bits live in the state
  always_ff @(posedge pclk) begin
    for (int w = 0; w < 2; w++) begin
      if (tb_we[w]) begin
        tb_tag_ff[w][m.va[14:9]] <= m.va[31:15]; // [RULE16]
        tb_pfn_ff[w][m.va[14:9]] <= m.wdata[20:0];
      end
      if (dcf_we && s_ff.way == w[0]) begin
        dc_tag_ff[w][s_ff.pa[11:3]] <= s_ff.pa[29:12]; // [RULE9]
        dc_data_ff[w][{s_ff.pa[11:3], 1'b0}] <= mem_rdata[31:0];
        dc_data_ff[w][{s_ff.pa[11:3], 1'b1}] <= mem_rdata[63:32];
      end
      if (dcw_we[w]) begin
        dc_data_ff[w][pa[11:2]] <= m.wdata; // [RULE13]
      end
    end
  end

  assign mem_req = s_ff.mem_req;
  assign mem_we = s_ff.mem_we;
  assign mem_quad = s_ff.mem_quad;
  assign mem_addr = s_ff.mem_addr;
  assign mem_wdata = s_ff.mem_wdata;
  assign m.done = s_ff.done;
  assign m.err = s_ff.err;
  assign m.rdata = s_ff.rdata;
  assign m.instruction_physical_address = s_ff.instruction_physical_address;
  assign m.prefetch_ok = s_ff.pok;
endmodule
`default_nettype wire

// >>> atdc_if.sv
`default_nettype none
interface atdc_if;
  logic cmd_valid;
  atdc_pkg::atdc_cmd_e cmd;
  logic [31:0] va;
  logic [31:0] wdata;
  logic [31:0] lookahead;
  logic phys;
  logic memory_mapping_enable;
  logic replace_both;
  logic permit;
  logic ib_advance;
  logic [1:0] tb_force_miss;
  logic [1:0] dc_force_miss;
  logic done;
  logic err;
  logic prefetch_ok;
  logic [31:0] rdata;
  logic [29:0] instruction_physical_address;
  modport dev (
    input cmd_valid, cmd, va, wdata, lookahead, phys, memory_mapping_enable, replace_both,
    input permit, ib_advance, tb_force_miss, dc_force_miss,
    output done, err, prefetch_ok, rdata, instruction_physical_address
  );
  modport req (
    output cmd_valid, cmd, va, wdata, lookahead, phys, memory_mapping_enable, replace_both,
    output permit, ib_advance, tb_force_miss, dc_force_miss,
    input done, err, prefetch_ok, rdata, instruction_physical_address
  );
endinterface
`default_nettype wire

// >>> atdc_lfsr.sv
`default_nettype none
`include "atdc_defines.svh"
module atdc_lfsr (
  input wire logic pclk,
  input wire logic presetn,
  output logic bit_o
);
  atdc_pkg::atdc_lfsr_s s_ff, nxt_s;
  // free-running, advances every clock
  always_comb begin
    nxt_s.sr = {s_ff.sr[14:0], ^(s_ff.sr & `ATDC_LFSR_TAPS)}; // [RULE23]
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff.sr <= `ATDC_LFSR_SEED;
    end else begin
      s_ff <= nxt_s;
    end
  end
  assign bit_o = s_ff.sr[0];
endmodule
`default_nettype wire

// >>> atdc_pkg.sv
`default_nettype none
package atdc_pkg;
`include "atdc_defines.svh"
  typedef enum logic [2:0] {
    CMD_READ = 3'b000,
    CMD_WRITE = 3'b001,
    CMD_NEWPC = 3'b010,
    CMD_IFETCH = 3'b011,
    CMD_TBWR = 3'b100,
    CMD_CCLR = 3'b101,
    CMD_FLUSH = 3'b110,
    CMD_RDWCHK = 3'b111
  } atdc_cmd_e;
  typedef enum logic [1:0] {
    D_IDLE = 2'b00,
    D_MEM = 2'b01,
    D_STALL = 2'b10
  } atdc_dst_e;
  typedef enum logic [1:0] {
    PS_VA = 2'b00,
    PS_IPA = 2'b01,
    PS_XLT = 2'b10
  } atdc_pasel_e;
  typedef enum logic {
    R_IDLE = 1'b0,
    R_BUSY = 1'b1
  } atdc_rst_e;
  typedef struct packed {
    logic [15:0] sr;
  } atdc_lfsr_s;
  typedef struct packed {
    atdc_dst_e st;
    logic [29:0] instruction_physical_address;
    logic ipa_ok, pcross, rl_go, rl_err, pok;
    logic [4:0] cnt;
    logic fill, way;
    logic [29:0] pa;
    logic [31:0] rdata;
    logic done, err;
    logic mem_req, mem_we, mem_quad;
    logic [29:0] mem_addr;
    logic [31:0] mem_wdata;
    logic [1:0][`ATDC_TB_SETS-1:0] tbv;
    logic [1:0][`ATDC_DC_SETS-1:0] dcv;
  } atdc_dev_s;
  typedef struct packed {
    atdc_rst_e st;
    logic [7:0] ctrl;
    logic [31:0] va, wdata, la, rdata, wchk_va, prdata;
    atdc_cmd_e cmd;
    logic cmd_v, permit, adv, rb, sweep, err, refused, wchk;
    logic [9:0] cnt;
    logic pready, pslverr;
  } atdc_req_s;
endpackage
`default_nettype wire

// >>> atdc_req.sv
`default_nettype none
`include "atdc_defines.svh"
module atdc_req (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  atdc_if.req m
);
  atdc_pkg::atdc_req_s s_ff, nxt_s;
  atdc_pkg::atdc_cmd_e c;
  logic [31:0] rd;
  logic [9:0] last;
  logic hit, acc, idle, swp;

  // sweep address for full clears
  function automatic logic [31:0] swp_va(input atdc_pkg::atdc_cmd_e k,
                                         input logic [9:0] n);
    if (k == atdc_pkg::CMD_TBWR) begin
      return {17'h0, n[5:0], 9'h0}; // [RULE16]
    end
    return {20'h0, n, 2'h0}; // [RULE15]
  endfunction

  always_comb begin
    nxt_s = s_ff;
    nxt_s.permit = 1'b0;
    nxt_s.adv = 1'b0;
    acc = psel && penable;
    idle = s_ff.st == atdc_pkg::R_IDLE;
    c = atdc_pkg::atdc_cmd_e'(pwdata[2:0]);
    swp = pwdata[`ATDC_K_SWEEP] &&
          (c == atdc_pkg::CMD_CCLR || c == atdc_pkg::CMD_TBWR);
    last = (s_ff.cmd == atdc_pkg::CMD_TBWR) ? 10'(`ATDC_TB_CLR_CNT - 1) :
           10'(`ATDC_DC_CLR_CNT - 1);
    if (s_ff.adv) begin
      nxt_s.la = s_ff.la + 32'h4;
    end
    rd = 32'h0;
    hit = 1'b1;
    case (paddr)
      `ATDC_R_CTRL: rd = {24'h0, s_ff.ctrl};
      `ATDC_R_VA: rd = s_ff.va;
      `ATDC_R_WDATA: rd = s_ff.wdata;
      `ATDC_R_CMD: rd = {29'h0, s_ff.cmd};
      `ATDC_R_STAT: rd = {27'h0, s_ff.wchk, s_ff.refused, m.prefetch_ok,
                          s_ff.err, !idle};
      `ATDC_R_RDATA: rd = s_ff.rdata;
      `ATDC_R_IPA: rd = {2'h0, m.instruction_physical_address};
      `ATDC_R_LA: rd = s_ff.la;
      default: hit = 1'b0;
    endcase
    if (acc && !s_ff.pready) begin
      nxt_s.pready = 1'b1;
      nxt_s.pslverr = !hit;
      nxt_s.prdata = rd;
    end else if (acc) begin
      nxt_s.pready = 1'b0;
      nxt_s.pslverr = 1'b0;
      if (pwrite && hit) begin
        case (paddr)
          `ATDC_R_CTRL: nxt_s.ctrl = pwdata[7:0];
          `ATDC_R_VA: begin
            if (idle) nxt_s.va = pwdata; // [RULE20]
            else nxt_s.refused = 1'b1;
          end
          `ATDC_R_WDATA: begin
            if (idle) nxt_s.wdata = pwdata; // [RULE20]
            else nxt_s.refused = 1'b1;
          end
          `ATDC_R_LA: begin
            if (idle) nxt_s.la = pwdata;
          end
          `ATDC_R_STAT: begin
            if (pwdata[`ATDC_S_REF]) nxt_s.refused = 1'b0;
            if (pwdata[`ATDC_S_ERR]) nxt_s.err = 1'b0;
          end
          `ATDC_R_CMD: begin
            nxt_s.permit = pwdata[`ATDC_K_PERMIT];
            nxt_s.adv = pwdata[`ATDC_K_ADV];
            if (!pwdata[`ATDC_K_GO]) begin
              nxt_s.refused = s_ff.refused;
            end else if (!idle ||
                (c == atdc_pkg::CMD_NEWPC && m.prefetch_ok) || // [RULE21]
                (c == atdc_pkg::CMD_WRITE && s_ff.wchk &&
                 s_ff.va != s_ff.wchk_va)) begin // [RULE22]
              nxt_s.refused = 1'b1;
            end else begin
              nxt_s.st = atdc_pkg::R_BUSY;
              nxt_s.cmd_v = 1'b1;
              nxt_s.cmd = c;
              nxt_s.sweep = swp;
              nxt_s.cnt = 10'h0;
              nxt_s.rb = s_ff.ctrl[`ATDC_C_RB] || swp;
              if (swp) nxt_s.va = swp_va(c, 10'h0);
              if (c == atdc_pkg::CMD_TBWR) begin
                nxt_s.wdata = swp ? 32'h0 : // [RULE16]
                              s_ff.wdata & `ATDC_TBE_MASK; // [RULE17]
              end
            end
          end
          default: ;
        endcase
      end
    end
    if (!idle && m.done) begin
      if (m.err) nxt_s.err = 1'b1;
      nxt_s.rdata = m.rdata;
      case (s_ff.cmd)
        atdc_pkg::CMD_RDWCHK: begin
          nxt_s.wchk = !m.err; // [RULE22]
          nxt_s.wchk_va = s_ff.va;
        end
        atdc_pkg::CMD_WRITE: nxt_s.wchk = 1'b0;
        atdc_pkg::CMD_NEWPC: begin
          if (!m.err) nxt_s.la = s_ff.va;
        end
        default: ;
      endcase
      if (s_ff.sweep && s_ff.cnt != last) begin
        nxt_s.cnt = s_ff.cnt + 10'h1; // [RULE15] [RULE16]
        nxt_s.va = swp_va(s_ff.cmd, s_ff.cnt + 10'h1);
      end else begin
        nxt_s.st = atdc_pkg::R_IDLE;
        nxt_s.cmd_v = 1'b0;
        nxt_s.sweep = 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign prdata = s_ff.prdata;
  assign pready = s_ff.pready;
  assign pslverr = s_ff.pslverr;
  assign m.cmd_valid = s_ff.cmd_v;
  assign m.cmd = s_ff.cmd;
  assign m.va = s_ff.va;
  assign m.wdata = s_ff.wdata;
  assign m.lookahead = s_ff.la;
  assign m.phys = s_ff.ctrl[`ATDC_C_PHYS];
  assign m.memory_mapping_enable = s_ff.ctrl[`ATDC_C_MME];
  assign m.replace_both = s_ff.rb;
  assign m.permit = s_ff.permit;
  assign m.ib_advance = s_ff.adv;
  assign m.tb_force_miss = s_ff.ctrl[`ATDC_C_TBFM+1:`ATDC_C_TBFM];
  assign m.dc_force_miss = s_ff.ctrl[`ATDC_C_DCFM+1:`ATDC_C_DCFM];
endmodule
`default_nettype wire

// >>> test_address_translation_and_data_cache.sv
`default_nettype none
`include "atdc_defines.svh"
module test_address_translation_and_data_cache;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, serr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, mem_wdata;
  logic mem_req, mem_we, mem_quad;
  logic mem_ack = 1'b0;
  logic [29:0] mem_addr;
  logic [63:0] mem_rdata = 64'h0;
  logic [31:0] store [logic [29:0]];
  int n_errors, checks, n_mem, md, n, i;
  atdc_if bus ();
  atdc_dev atdc_dev_inst (.pclk(pclk), .presetn(presetn), .m(bus.dev),
    .mem_req(mem_req), .mem_we(mem_we), .mem_quad(mem_quad),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata));
  atdc_req atdc_req_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .m(bus.req));
  atdc_chk atdc_chk_inst (.pclk(pclk), .presetn(presetn),
    .cmd_valid(bus.cmd_valid), .permit(bus.permit),
    .ib_advance(bus.ib_advance), .done(bus.done),
    .prefetch_ok(bus.prefetch_ok), .instruction_physical_address(bus.instruction_physical_address), .mem_req(mem_req),
    .mem_we(mem_we), .mem_quad(mem_quad), .mem_addr(mem_addr),
    .mem_ack(mem_ack));
  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end
  function automatic logic [31:0] mv(input logic [29:0] a);
    return store.exists(a) ? store[a] : {2'h0, a} ^ 32'hC3C3_0000;
  endfunction
  // memory: answers after a few cycles, data line garbled outside ack
  always @(posedge pclk) begin
    md <= (mem_req && !mem_ack) ? md + 1 : 0;
    if (mem_req && !mem_ack && md == 2) begin
      mem_ack <= 1'b1;
      n_mem <= n_mem + 1;
      if (mem_we)
        store[mem_addr] = mem_wdata;
      else
        mem_rdata <= {mv(mem_addr | 30'h4), mv(mem_addr)};
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
    end
  end
  task automatic chk(input string s, input logic [31:0] got, exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h seen %h", s, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk);
    while (pready !== 1'b1);
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic st(input int b, input logic e);
    apb(1'b0, `ATDC_R_STAT, 32'h0);
    chk("status bit", rd[b], e);
  endtask
  task automatic op(input atdc_pkg::atdc_cmd_e c, input logic [31:0] va,
                    input logic [3:0] f);
    apb(1'b1, `ATDC_R_VA, va);
    apb(1'b1, `ATDC_R_CMD, {25'h0, f, c});
    do apb(1'b0, `ATDC_R_STAT, 32'h0);
    while (rd[`ATDC_S_BUSY] !== 1'b0);
  endtask
  task automatic rdchk(input logic [31:0] va, input logic [31:0] exp,
                       input atdc_pkg::atdc_cmd_e c = atdc_pkg::CMD_READ);
    op(c, va, 4'h1);
    apb(1'b0, `ATDC_R_RDATA, 32'h0);
    chk("rdata", rd, exp);
  endtask
  task automatic finish_test();
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #300000;
    n_errors++;
    finish_test();
  end
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `ATDC_R_STAT, 32'h0);
    chk("status", rd, 32'h0);
    apb(1'b0, 8'h20, 32'h0);
    chk("pslverr", serr, 1'b1);
    $display("test reset done");
    n = n_mem;
    rdchk(32'h1008, mv(30'h1008));
    rdchk(32'h100C, mv(30'h100C));
    chk("fills", n_mem - n, 1);
    apb(1'b1, `ATDC_R_WDATA, 32'h1234_5678);
    op(atdc_pkg::CMD_WRITE, 32'h1008, 4'h1);
    chk("write thru", mv(30'h1008), 32'h1234_5678);
    rdchk(32'h1008, 32'h1234_5678);
    chk("hit", n_mem - n, 2);
    op(atdc_pkg::CMD_WRITE, 32'h2000, 4'h1);
    rdchk(32'h2000, 32'h1234_5678);
    chk("no alloc", n_mem - n, 4);
    rdchk(32'h2000_0010, mv(30'h2000_0010));
    rdchk(32'h2000_0010, mv(30'h2000_0010));
    chk("io", n_mem - n, 6);
    op(atdc_pkg::CMD_CCLR, 32'h0, 4'h9);
    rdchk(32'h100C, mv(30'h100C));
    chk("clear", n_mem - n, 7);
    apb(1'b1, `ATDC_R_CTRL, 32'hC0);
    rdchk(32'h100C, mv(30'h100C));
    rdchk(32'h100C, mv(30'h100C));
    chk("forced", n_mem - n, 9);
    apb(1'b1, `ATDC_R_VA, 32'h2000_0020);
    apb(1'b1, `ATDC_R_CMD, {28'h0, 1'b1, atdc_pkg::CMD_READ});
    apb(1'b1, `ATDC_R_VA, 32'h55);
    do apb(1'b0, `ATDC_R_STAT, 32'h0);
    while (rd[`ATDC_S_BUSY] !== 1'b0);
    chk("refused", rd[`ATDC_S_REF], 1'b1);
    apb(1'b0, `ATDC_R_VA, 32'h0);
    chk("va held", rd, 32'h2000_0020);
    op(atdc_pkg::CMD_RDWCHK, 32'h3000, 4'h1);
    st(`ATDC_S_WCHK, 1'b1);
    op(atdc_pkg::CMD_WRITE, 32'h3004, 4'h1);
    op(atdc_pkg::CMD_WRITE, 32'h3000, 4'h1);
    st(`ATDC_S_WCHK, 1'b0);
    chk("pairing", n_mem - n, 12);
    $display("test cache done");
    apb(1'b1, `ATDC_R_CTRL, 32'h1);
    apb(1'b1, `ATDC_R_WDATA, 32'hFFE0_0003);
    op(atdc_pkg::CMD_TBWR, 32'hA00, 4'h1);
    apb(1'b0, `ATDC_R_WDATA, 32'h0);
    chk("entry mask", rd, 32'h8000_0003);
    rdchk(32'hA10, mv(30'h610));
    op(atdc_pkg::CMD_READ, 32'h8A10, 4'h1);
    st(`ATDC_S_ERR, 1'b1);
    apb(1'b1, `ATDC_R_CTRL, 32'h3);
    rdchk(32'hA10, mv(30'hA10));
    apb(1'b1, `ATDC_R_CTRL, 32'h5);
    apb(1'b1, `ATDC_R_WDATA, 32'h0);
    op(atdc_pkg::CMD_TBWR, 32'h0, 4'h9);
    apb(1'b1, `ATDC_R_CTRL, 32'h1);
    apb(1'b1, `ATDC_R_STAT, 32'hA);
    op(atdc_pkg::CMD_READ, 32'hA10, 4'h1);
    st(`ATDC_S_ERR, 1'b1);
    $display("test lookaside done");
    apb(1'b1, `ATDC_R_CTRL, 32'h0);
    apb(1'b1, `ATDC_R_STAT, 32'hA);
    op(atdc_pkg::CMD_NEWPC, 32'h1F8, 4'h1);
    apb(1'b0, `ATDC_R_IPA, 32'h0);
    chk("ipa", rd, 32'h1F8);
    rdchk(32'h0, mv(30'h1F8), atdc_pkg::CMD_IFETCH);
    op(atdc_pkg::CMD_READ, 32'h0, 4'h4);
    apb(1'b0, `ATDC_R_IPA, 32'h0);
    chk("ipa step", rd, 32'h1FC);
    op(atdc_pkg::CMD_READ, 32'h0, 4'h4);
    st(`ATDC_S_POK, 1'b0);
    op(atdc_pkg::CMD_READ, 32'h0, 4'h2);
    apb(1'b0, `ATDC_R_IPA, 32'h0);
    chk("reload", rd, 32'h200);
    st(`ATDC_S_POK, 1'b1);
    op(atdc_pkg::CMD_NEWPC, 32'h1000, 4'h1);
    st(`ATDC_S_REF, 1'b1);
    apb(1'b0, `ATDC_R_IPA, 32'h0);
    chk("ipa kept", rd, 32'h200);
    for (i = 0; i < 128; i++) begin
      op(atdc_pkg::CMD_READ, 32'h0, 4'h4);
    end
    apb(1'b1, `ATDC_R_CTRL, 32'h1);
    op(atdc_pkg::CMD_READ, 32'h0, 4'h2);
    st(`ATDC_S_POK, 1'b0);
    op(atdc_pkg::CMD_IFETCH, 32'h0, 4'h1);
    st(`ATDC_S_ERR, 1'b1);
    op(atdc_pkg::CMD_FLUSH, 32'h0, 4'h1);
    apb(1'b1, `ATDC_R_CTRL, 32'h0);
    op(atdc_pkg::CMD_READ, 32'h0, 4'h2);
    st(`ATDC_S_POK, 1'b1);
    $display("test prefetch done");
    finish_test();
  end
endmodule
`default_nettype wire
